/* common/sba_pkg.sv */
// Shared constants and types of the system bus priority arbiter
package sba_pkg;

  // Priority positions, highest first; index 0 outranks all others
  localparam int unsigned NUM_MASTERS   = 11;
  localparam int unsigned DMA_COUNT     = 4;
  localparam int unsigned DMA_PTR_W     = 2;
  localparam int unsigned IDX_REFRESH   = 0;
  localparam int unsigned IDX_DISPLAY   = 1;
  localparam int unsigned IDX_DMA_BASE  = 2;
  localparam int unsigned IDX_USB       = 6;
  localparam int unsigned IDX_OFFCHIP   = 7;
  localparam int unsigned IDX_TEST      = 8;
  localparam int unsigned IDX_CPU       = 9;
  localparam int unsigned IDX_RESERVED  = 10;

  localparam logic [DMA_PTR_W-1:0]   DMA_PTR_RESET = 2'h0;
  localparam logic [NUM_MASTERS-1:0] GRANT_NONE    = 11'h000;

  // One bit per bus master; the last field is bit 0, the top position
  typedef struct packed {
    logic reserved;
    logic cpu_core;
    logic test_interface_controller;
    logic offchip_requester;
    logic usb_host_dma;
    logic general_channel_three;
    logic general_channel_two;
    logic general_channel_one;
    logic general_channel_zero;
    logic display_dma_master;
    logic refresh;
  } sba_master_type;

  typedef enum logic [1:0] {
    SBA_IDLE  = 2'h0,
    SBA_OWNED = 2'h1
  } sba_fsm_type;

  typedef struct packed {
    sba_fsm_type                 fsm;
    sba_master_type              grant;
    logic [DMA_PTR_W-1:0]        rot_ptr;
  } sba_state_type;

endpackage

/* hdl/sba_dma_rotator.sv */
// Rotating pick among the general purpose DMA channels
`timescale 1ns/1ps
`default_nettype none

module sba_dma_rotator #(
  parameter int unsigned CHANNELS = 4,
  parameter int unsigned PTR_W    = 2
) (
  input  wire logic [CHANNELS-1:0] req,
  input  wire logic [PTR_W-1:0]    ptr,
  output logic      [CHANNELS-1:0] pick
);

  ////////////////////////////////////////////////////////////////////////////
  // First requester at or after the pointer, wrapping round
  always_comb begin
    logic             found;
    logic [PTR_W-1:0] idx;
    found = 1'b0;
    idx   = '0;
    pick  = '0;
    for (int unsigned i = 0; i < CHANNELS; i++) begin
      idx = ptr + PTR_W'(i);                                 // see [R4]
      if (!found && req[idx]) begin
        pick[idx] = 1'b1;
        found     = 1'b1;
      end
    end
  end

endmodule // sba_dma_rotator

`default_nettype wire

/* hdl/sba_arbiter.sv */
// System bus arbiter: fixed ranks around a rotating DMA band
//
// Summary of operation
// [R1] Grant bus to one master, fixed plus rotation
// [R2] Eleven priority positions including one reserved
// [R3] Reset order refresh, display, DMA, usb, ... cpu
// [R4] DMA channels rotate priority within their band
// [R5] Non-DMA masters keep fixed rank around band
// [R6] Granted channel drops lowest; reserved never granted
`timescale 1ns/1ps
`default_nettype none

module sba_arbiter (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire sba_pkg::sba_master_type req,
  output logic                         bus_busy,
  output sba_pkg::sba_master_type      grant
);
  import sba_pkg::*;

  sba_state_type                st;
  sba_state_type                next_st;
  logic [NUM_MASTERS-1:0]       req_vec;                     // see [R2]
  logic [NUM_MASTERS-1:0]       grant_vec;
  logic [DMA_COUNT-1:0]         dma_req;
  logic [DMA_COUNT-1:0]         dma_pick;
  logic [NUM_MASTERS-1:0]       winner;
  logic                         owner_holds;

  assign req_vec   = req;
  assign grant_vec = st.grant;
  assign dma_req   = req_vec[IDX_DMA_BASE +: DMA_COUNT];

  ////////////////////////////////////////////////////////////////////////////
  // DMA band pick
  sba_dma_rotator #(
    .CHANNELS (DMA_COUNT),
    .PTR_W    (DMA_PTR_W)
  ) u_rotator (
    .req  (dma_req),
    .ptr  (st.rot_ptr),
    .pick (dma_pick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Winner selection
  always_comb begin
    winner = '0;
    if (req_vec[IDX_REFRESH]) begin                          // see [R3]
      winner[IDX_REFRESH] = 1'b1;
    end else if (req_vec[IDX_DISPLAY]) begin                 // see [R5]
      winner[IDX_DISPLAY] = 1'b1;
    end else if (|dma_req) begin                             // see [R4]
      winner[IDX_DMA_BASE +: DMA_COUNT] = dma_pick;
    end else begin
      for (int unsigned i = IDX_USB; i <= IDX_CPU; i++) begin  // see [R5]
        if (req_vec[i] && winner == '0) begin
          winner[i] = 1'b1;
        end
      end
    end
    // Reserved position is never considered                // see [R6]
  end

  assign owner_holds = |(grant_vec & req_vec);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    case (st.fsm)
      SBA_IDLE: begin
        if (winner != '0) begin                              // see [R1]
          next_st.fsm   = SBA_OWNED;
          next_st.grant = winner;
          for (int unsigned k = 0; k < DMA_COUNT; k++) begin
            if (winner[IDX_DMA_BASE + k]) begin
              next_st.rot_ptr = DMA_PTR_W'(k + 1);           // see [R6]
            end
          end
        end
      end
      SBA_OWNED: begin
        if (!owner_holds) begin
          next_st.fsm   = SBA_IDLE;
          next_st.grant = GRANT_NONE;
        end
      end
      default: begin
        next_st.fsm   = SBA_IDLE;
        next_st.grant = GRANT_NONE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st.fsm     <= SBA_IDLE;
      st.grant   <= GRANT_NONE;
      st.rot_ptr <= DMA_PTR_RESET;                           // see [R3]
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, straight from the state register
  assign grant    = st.grant;
  assign bus_busy = (st.fsm == SBA_OWNED);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [NUM_MASTERS-1:0] higher_than_cpu;
  assign higher_than_cpu = req_vec & {2'h0, {IDX_CPU{1'b1}}};

  sequence arb_slot_s;
    st.fsm == SBA_IDLE;
  endsequence

  sequence dma_won_s(int unsigned k);
    arb_slot_s ##0 (winner[IDX_DMA_BASE + k]) ##1 grant_vec[IDX_DMA_BASE + k];
  endsequence

  grant_single_a: assert property ($onehot0(grant_vec)) // see [R1]
    else $error("more than one master granted");

  reserved_never_a: assert property (!grant.reserved) // see [R6]
    else $error("reserved position granted");

  refresh_first_a: assert property (arb_slot_s ##0 req.refresh |=> grant.refresh) // see [R3]
    else $error("refresh request not granted first");

  display_over_band_a: assert property ( // see [R5]
    arb_slot_s ##0 (req.display_dma_master && !req.refresh) |=> grant.display_dma_master)
    else $error("display DMA lost to a lower master");

  band_over_cpu_a: assert property ( // see [R5]
    arb_slot_s ##0 (|dma_req && !req.refresh && !req.display_dma_master)
      |=> (|grant_vec[IDX_DMA_BASE +: DMA_COUNT]))
    else $error("DMA band lost to a lower master");

  cpu_last_a: assert property ( // see [R3]
    arb_slot_s ##0 (higher_than_cpu != '0) |=> !grant.cpu_core)
    else $error("cpu granted over a higher master");

  rotate_zero_a: assert property (dma_won_s(0) |-> st.rot_ptr == 2'h1) // see [R6]
    else $error("channel zero not moved to band bottom");

  rotate_three_a: assert property (dma_won_s(3) |-> st.rot_ptr == 2'h0) // see [R6]
    else $error("channel three not moved to band bottom");

  owner_hold_a: assert property ( // see [R1]
    (bus_busy && owner_holds) |=> (bus_busy && $stable(grant_vec)))
    else $error("grant lost while owner still requests");

  release_idle_a: assert property ( // see [R1]
    (bus_busy && !owner_holds) |=> (!bus_busy ##1 (bus_busy == (|$past(winner)))))
    else $error("bus not released and rearbitrated");

  ////////////////////////////////////////////////////////////////////////////
  // Rank, rotation and hand-over details
  sequence band_open_s;
    arb_slot_s ##0 (!req.refresh && !req.display_dma_master);
  endsequence

  busy_grant_a: assert property ( // see [R1]
    bus_busy == (grant_vec != GRANT_NONE))
    else $error("busy flag and grant disagree");

  idle_no_req_a: assert property ( // see [R1]
    arb_slot_s ##0 (req_vec[IDX_CPU:0] == '0) |=> !bus_busy)
    else $error("bus taken with no request");

  grant_from_req_a: assert property ( // see [R1]
    arb_slot_s ##1 bus_busy |-> |(grant_vec & $past(req_vec)))
    else $error("grant given to a silent master");

  dead_cycle_a: assert property ( // see [R1]
    (bus_busy && !owner_holds) |=> (grant_vec == GRANT_NONE))
    else $error("no dead cycle between owners");

  hold_no_preempt_a: assert property ( // see [R1]
    (bus_busy && owner_holds && !grant.refresh) |=> !grant.refresh)
    else $error("owner preempted while still requesting");

  dma_single_a: assert property ( // see [R4]
    $onehot0(dma_pick))
    else $error("more than one DMA channel picked");

  pick_needs_req_a: assert property ( // see [R4]
    (dma_pick & ~dma_req) == '0)
    else $error("DMA channel picked without request");

  band_pointer_a: assert property ( // see [R4]
    band_open_s ##0 dma_req[st.rot_ptr]
      |=> grant_vec[IDX_DMA_BASE + $past(st.rot_ptr)])
    else $error("band top channel passed over");

  rotate_one_a: assert property (dma_won_s(1) |-> st.rot_ptr == 2'h2) // see [R6]
    else $error("channel one not moved to band bottom");

  rotate_two_a: assert property (dma_won_s(2) |-> st.rot_ptr == 2'h3) // see [R6]
    else $error("channel two not moved to band bottom");

  ptr_steady_a: assert property ( // see [R6]
    (st.fsm != SBA_IDLE || winner[IDX_DMA_BASE +: DMA_COUNT] == '0)
      |=> $stable(st.rot_ptr))
    else $error("rotation moved without a DMA grant");

  // Each master from usb to cpu wins once every higher position is quiet
  for (genvar p = IDX_USB; p <= IDX_CPU; p++) begin : g_fixed_rank
    fixed_rank_a: assert property (@(posedge clk) disable iff (rst) // see [R5]
      arb_slot_s ##0 (req_vec[p] && req_vec[p-1:0] == '0) |=> grant_vec[p])
      else $error("lower master won over a higher one");
  end

endmodule // sba_arbiter

`default_nettype wire

/* verif/sba_master_model.sv */
// Bus master group that requests the bus and releases it once served
`timescale 1ns/1ps
`default_nettype none

module sba_master_model (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    load,
  input  wire sba_pkg::sba_master_type want,
  input  wire sba_pkg::sba_master_type grant,
  output sba_pkg::sba_master_type      req
);
  import sba_pkg::*;
  // Request held until granted, dropped after one owned cycle
  always_ff @(negedge clk) begin
    if (rst) begin
      req <= GRANT_NONE;
    end else if (load) begin
      req <= want;
    end else begin
      req <= req & ~grant;
    end
  end
endmodule // sba_master_model
`default_nettype wire

/* verif/system_bus_priority_arbiter_test.sv */
// Self-checking bench of the system bus arbiter
`timescale 1ns/1ps
`default_nettype none

module system_bus_priority_arbiter_test;
  import sba_pkg::*;
  logic           clk  = 1'b0;
  logic           rst  = 1'b1;
  logic           load = 1'b0;
  sba_master_type want = GRANT_NONE;
  sba_master_type req;
  sba_master_type grant;
  logic           bus_busy;
  int             error_cnt = 0;
  int             checked = 0;
  sba_master_type exp_q[$];

  initial forever #25 clk = ~clk;

  sba_arbiter sba_arbiter_inst (.clk(clk), .rst(rst), .req(req), .bus_busy(bus_busy),
    .grant(grant));
  sba_master_model sba_master_model_inst (.clk(clk), .rst(rst), .load(load),
    .want(want), .grant(grant), .req(req));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic push(input int i);
    exp_q.push_back(sba_master_type'(11'h001 << i));
  endtask

  // Loads a request mask and compares every grant with the queue
  task automatic serve(input logic [10:0] mask);
    int n;
    int t;
    n = 0;
    @(negedge clk);
    want <= mask;
    load <= 1'b1;
    @(negedge clk);
    load <= 1'b0;
    @(negedge clk);
    for (t = 0; t < 80 && (req[9:0] !== 10'h000 || grant !== GRANT_NONE); t++) begin
      if (grant !== GRANT_NONE) begin
        chk(grant, (n < exp_q.size()) ? exp_q[n] : GRANT_NONE);
        chk({10'h000, bus_busy}, 11'h001);
        n++;
      end else begin
        chk({10'h000, bus_busy}, 11'h000);
      end
      @(negedge clk);
    end
    if (t == 80) begin
      error_cnt++;
      give_verdict();
    end
    chk(11'(n), 11'(exp_q.size()));
    exp_q.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    chk(grant, GRANT_NONE);
    chk({10'h000, bus_busy}, 11'h000);
  endtask

  // All masters at once, reserved one included
  task automatic s_full();
    for (int i = 0; i < 10; i++) push(i);
    serve(11'h7FF);
  endtask

  // Channel one served alone, then the band rotates from channel two
  task automatic s_rotate();
    push(3);
    serve(11'h008);
    push(1);
    push(4);
    push(5);
    push(2);
    push(3);
    push(9);
    serve(11'h23E);
  endtask

  // Owner keeps the bus while refresh waits, then hands over after a dead cycle
  task automatic s_hold();
    @(negedge clk);
    want <= 11'h200;
    load <= 1'b1;
    repeat (2) @(negedge clk);
    chk(grant, 11'h200);
    want <= 11'h201;
    repeat (2) @(negedge clk);
    chk(grant, 11'h200);
    want <= 11'h001;
    repeat (2) @(negedge clk);
    chk(grant, GRANT_NONE);
    chk({10'h000, bus_busy}, 11'h000);
    @(negedge clk);
    chk(grant, 11'h001);
    want <= GRANT_NONE;
    @(negedge clk);
    load <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // Reset in mid-run puts channel zero back at the top of the band
  task automatic s_rerun();
    @(negedge clk);
    rst <= 1'b1;
    repeat (2) @(negedge clk);
    rst <= 1'b0;
    @(negedge clk);
    s_reset();
    push(2);
    push(3);
    push(4);
    push(5);
    serve(11'h03C);
  endtask

  initial begin
    repeat (2) @(negedge clk);
    rst <= 1'b0;
    @(negedge clk);
    s_reset();
    s_full();
    s_rotate();
    s_hold();
    s_rerun();
    give_verdict();
  end
endmodule // system_bus_priority_arbiter_test
`default_nettype wire
